/* core/sdirx_mode_ctrl.sv */
// Behaviour
// - The parallel output is 20 bits wide with bus_width_select high, 10 bits wide with it low.
// - With video_processing_enable high every received word goes through the processing stage.
// - With video_processing_enable low the processing stage is bypassed for lower latency.
// - With serial_output_enable low both loop-through lines are forced high.
// - With serial_output_enable high the loop-through lines are driven with the serial data.
// - In standby no data is processed and the digital outputs are powered down.
// - In standby both loop-through lines are held high whatever serial_output_enable says.
// - The loop-through only carries data at the five supported receiver line rates.
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/100ps

module sdirx_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 16
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_flush,
    input wire logic [WIDTH-1:0] i_data,
    input wire logic i_valid,
    output logic o_ready,
    output logic [WIDTH-1:0] o_data,
    output logic o_valid,
    input wire logic i_ready,
    output logic [$clog2(DEPTH):0] o_level
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_LEVEL = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    wire push = i_valid && o_ready;
    wire pop = o_valid && i_ready;

    assign o_ready = (cnt_q != FULL_LEVEL) && !i_flush;
    assign o_valid = (cnt_q != '0) && !i_flush;
    assign o_data = mem_q[rd_q];
    assign o_level = cnt_q;

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_q[wr_q] <= i_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn || i_flush) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= push ? wr_q + 1'b1 : wr_q;
            rd_q <= pop ? rd_q + 1'b1 : rd_q;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule : sdirx_fifo

module sdirx_mode_ctrl (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire sdirx_pkg::sdirx_pins_s i_pins,
    input wire logic [2:0] i_rate,
    input wire logic i_sdi_bit,
    input wire sdirx_pkg::sdirx_word_s i_rx_word,
    input wire logic i_rx_valid,
    output logic o_rx_ready,
    output logic [sdirx_pkg::WORD_W-1:0] o_pdata,
    output logic o_pvalid,
    input wire logic i_pready,
    output logic o_io_enable,
    output logic o_sdo_p,
    output logic o_sdo_n,
    input wire logic [sdirx_pkg::ADDR_W-1:0] i_addr,
    input wire logic [sdirx_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [sdirx_pkg::DATA_W-1:0] o_rdata
);
    import sdirx_pkg::*;

    // Pin synchronisers
    sdirx_pins_s s1_q;
    sdirx_pins_s s2_q;
    sdirx_pins_s s3_q;
    sdirx_pins_s pins_q;
    wire [3:0] agree = ~(s2_q ^ s3_q);
    wire sdirx_pins_s pins_d = (s2_q & agree) | (pins_q & ~agree);

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            pins_q <= '0;
        end else begin
            s1_q <= i_pins;
            s2_q <= s1_q;
            s3_q <= s2_q;
            pins_q <= pins_d;
        end
    end

    wire width20 = pins_q.bus_width_select;
    wire proc_en = pins_q.video_processing_enable;
    wire sdo_en = pins_q.serial_output_enable;
    wire standby = pins_q.standby;

    // Registers
    logic [DATA_W-1:0] ctrl_q;
    logic [COUNT_W-1:0] count_q;
    logic [DATA_W-1:0] rdata_q;
    logic [2:0] rate_q;
    logic [LEVEL_W-1:0] level;
    wire clip_en = ctrl_q[CTRL_CLIP_BIT];
    wire wr_ctrl = i_wr && (i_addr == REG_CTRL);
    wire [DATA_W-1:0] status_word = DATA_W'({rate_q, 3'h0, level, standby, sdo_en,
        proc_en, width20});
    wire [DATA_W-1:0] rd_mux = (i_addr == REG_CTRL) ? ctrl_q :
        (i_addr == REG_STATUS) ? status_word :
        (i_addr == REG_COUNT) ? count_q : '0;

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            ctrl_q <= CTRL_RESET;
            rdata_q <= '0;
        end else begin
            ctrl_q <= wr_ctrl ? (i_wdata & CTRL_RESET) : ctrl_q;
            rdata_q <= i_rd ? rd_mux : '0;
        end
    end
    assign o_rdata = rdata_q;

    // Processing stage
    function automatic logic [9:0] clip_half(input logic [9:0] v);
        clip_half = (v < LEGAL_MIN) ? LEGAL_MIN : (v > LEGAL_MAX) ? LEGAL_MAX : v;
    endfunction : clip_half

    sdirx_word_s st_q;
    logic st_v_q;
    logic fifo_in_ready;
    wire sdirx_word_s proc_word = clip_en ?
        {clip_half(i_rx_word.hi), clip_half(i_rx_word.lo)} : i_rx_word;
    wire st_free = !st_v_q || fifo_in_ready;
    wire fifo_in_valid = !standby && (proc_en ? st_v_q : (st_v_q || i_rx_valid));
    wire sdirx_word_s fifo_in_data = st_v_q ? st_q : i_rx_word;
    wire rx_take = i_rx_valid && o_rx_ready;

    assign o_rx_ready = !standby && (proc_en ? st_free : (!st_v_q && fifo_in_ready));

    always_ff @(posedge i_clk) begin
        if (!i_resetn || standby) begin
            st_v_q <= 1'b0;
            st_q <= '0;
        end else if (proc_en && st_free) begin
            st_v_q <= i_rx_valid;
            st_q <= proc_word;
        end else if (!proc_en && fifo_in_ready) begin
            st_v_q <= 1'b0;
        end
    end

    // Buffer
    sdirx_word_s f_data;
    logic f_valid;
    logic f_pop;

    sdirx_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_flush(standby),
        .i_data(fifo_in_data),
        .i_valid(fifo_in_valid),
        .o_ready(fifo_in_ready),
        .o_data(f_data),
        .o_valid(f_valid),
        .i_ready(f_pop),
        .o_level(level)
    );

    // Output sequencer
    sdirx_ostate_e ostate_q;
    sdirx_ostate_e ostate_d;
    logic [WORD_W-1:0] pdata_q;
    logic pvalid_q;
    logic [WORD_W-1:0] pdata_d;
    wire out_free = !pvalid_q || i_pready;
    wire out_load = out_free && f_valid;

    always_comb begin
        ostate_d = ostate_q;
        pdata_d = f_data;
        f_pop = 1'b0;
        if (width20) begin
            ostate_d = OS_FIRST;
            f_pop = out_load;
        end else begin
            case (ostate_q)
                OS_FIRST: begin
                    pdata_d = {HALF_ZERO, f_data.hi};
                    ostate_d = out_load ? OS_SECOND : OS_FIRST;
                end
                OS_SECOND: begin
                    pdata_d = {HALF_ZERO, f_data.lo};
                    f_pop = out_load;
                    ostate_d = out_load ? OS_FIRST : OS_SECOND;
                end
                default: begin
                    ostate_d = OS_FIRST;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn || standby) begin
            ostate_q <= OS_FIRST;
            pvalid_q <= 1'b0;
            pdata_q <= '0;
        end else begin
            ostate_q <= ostate_d;
            pvalid_q <= out_load || (pvalid_q && !i_pready);
            pdata_q <= out_load ? pdata_d : pdata_q;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            count_q <= '0;
        end else if (f_pop) begin
            count_q <= count_q + 1'b1;
        end
    end

    assign o_pdata = pdata_q;
    assign o_pvalid = pvalid_q;
    assign o_io_enable = !standby;

    // Serial loop-through
    logic sdo_p_q;
    logic sdo_n_q;
    wire rate_ok = rate_q < RATE_COUNT;
    wire sdo_drive = sdo_en && !standby && rate_ok;

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            rate_q <= RATE_2G97;
            sdo_p_q <= 1'b1;
            sdo_n_q <= 1'b1;
        end else begin
            rate_q <= i_rate;
            sdo_p_q <= sdo_drive ? i_sdi_bit : 1'b1;
            sdo_n_q <= sdo_drive ? !i_sdi_bit : 1'b1;
        end
    end

    assign o_sdo_p = sdo_p_q;
    assign o_sdo_n = sdo_n_q;

    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    chk_ten_bit_upper: assert property (
        (out_load && !width20 && !standby) |=> (o_pdata[19:10] == HALF_ZERO))
        else $error("upper half not zero in 10-bit mode");

    chk_ten_bit_pairs: assert property (
        (out_load && !width20 && !standby && ostate_q == OS_FIRST) |-> !f_pop ##1
        (ostate_q == OS_SECOND))
        else $error("10-bit word not split in two beats");

    chk_proc_stage: assert property (
        (proc_en && rx_take) |=> (st_v_q && st_q == $past(proc_word)))
        else $error("processed word not held in stage");

    chk_bypass_direct: assert property (
        (!proc_en && rx_take) |-> (fifo_in_valid && fifo_in_data == i_rx_word))
        else $error("bypass word not passed straight through");

    chk_sdo_off_high: assert property (
        !sdo_en |=> (o_sdo_p && o_sdo_n))
        else $error("loop-through not high when disabled");

    chk_sdo_follows: assert property (
        (sdo_en && !standby && rate_ok) |=>
        (o_sdo_p == $past(i_sdi_bit) && o_sdo_n != o_sdo_p))
        else $error("loop-through not driven with serial data");

    chk_standby_quiet: assert property (
        standby |-> !o_rx_ready && !o_io_enable ##1 (!o_pvalid && o_pdata == '0))
        else $error("outputs active in standby");

    chk_standby_sdo: assert property (
        (standby && sdo_en) |=> (o_sdo_p && o_sdo_n))
        else $error("loop-through not high in standby");

    chk_rate_gate: assert property (
        !rate_ok |=> (o_sdo_p && o_sdo_n))
        else $error("loop-through driven at unsupported rate");

    chk_pin_sync: assert property (
        (i_resetn && $stable(i_pins))[*5] |=> (pins_q == $past(i_pins)))
        else $error("control pin not taken after synchronising");

    chk_twenty_bit_word: assert property (
        (out_load && width20 && !standby) |=> (o_pvalid && o_pdata == $past(f_data)))
        else $error("20-bit beat does not carry the whole word");

    chk_ten_bit_low: assert property (
        (out_load && !width20 && !standby && ostate_q == OS_SECOND) |=>
        (o_pdata[9:0] == $past(f_data.lo) && ostate_q == OS_FIRST))
        else $error("10-bit low beat wrong");

    chk_clip_range: assert property (
        (proc_en && rx_take && clip_en) |=> (st_q.hi >= LEGAL_MIN && st_q.hi <= LEGAL_MAX &&
        st_q.lo >= LEGAL_MIN && st_q.lo <= LEGAL_MAX))
        else $error("processed word outside legal range");

    chk_standby_flush: assert property (
        standby |=> (level == '0 && !st_v_q))
        else $error("buffer not flushed in standby");

    cov_ten_bit_pair: cover property (
        (ostate_q == OS_SECOND && f_pop && !width20));

    cov_standby_entry: cover property (
        $rose(standby) && pvalid_q);

    cov_fifo_full: cover property (
        !fifo_in_ready && !standby);

    cov_clip_off: cover property (
        proc_en && rx_take && !clip_en);

    cov_bypass_take: cover property (
        !proc_en && rx_take && fifo_in_ready);

endmodule : sdirx_mode_ctrl

/* core/sdirx_pkg.sv */
package sdirx_pkg;

    // Register port
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_COUNT = 8'h08;

    // Control register fields
    localparam int CTRL_CLIP_BIT = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

    // Status register fields
    localparam int ST_WIDTH_BIT = 0;
    localparam int ST_PROC_BIT = 1;
    localparam int ST_SDO_BIT = 2;
    localparam int ST_STBY_BIT = 3;
    localparam int ST_LEVEL_LSB = 4;
    localparam int ST_RATE_LSB = 12;

    // Datapath shape
    localparam int HALF_W = 10;
    localparam int WORD_W = 20;
    localparam int FIFO_DEPTH = 16;
    localparam int LEVEL_W = 5;
    localparam int COUNT_W = 32;
    localparam logic [9:0] LEGAL_MIN = 10'h004;
    localparam logic [9:0] LEGAL_MAX = 10'h3fb;
    localparam logic [9:0] HALF_ZERO = 10'h000;

    // Loop-through line rates
    typedef enum logic [2:0] {
        RATE_2G97,
        RATE_2G97_FRAC,
        RATE_1G485,
        RATE_1G485_FRAC,
        RATE_270M,
        RATE_COUNT
    } sdirx_rate_e;

    // Control pins
    typedef struct packed {
        logic bus_width_select;
        logic video_processing_enable;
        logic serial_output_enable;
        logic standby;
    } sdirx_pins_s;

    typedef struct packed {
        logic [9:0] hi;
        logic [9:0] lo;
    } sdirx_word_s;

    typedef enum logic {OS_FIRST, OS_SECOND} sdirx_ostate_e;

endpackage : sdirx_pkg

/* dv/sdirx_cable_model.sv */
`timescale 1ns/100ps
module sdirx_cable_model (
    input wire logic i_sdo_p,
    input wire logic i_sdo_n,
    output logic o_idle,
    output logic o_bit
);
    // Both lines high means the stage is parked
    assign o_idle = i_sdo_p & i_sdo_n;
    assign o_bit = i_sdo_p & ~i_sdo_n;
endmodule : sdirx_cable_model

/* dv/sdirx_mode_ctrl_test.sv */
`timescale 1ns/100ps
module sdirx_mode_ctrl_test;
    import sdirx_pkg::*;
    logic i_clk = 0;
    logic i_resetn = 0;
    sdirx_pins_s i_pins = '0;
    logic [2:0] i_rate = 3'h0;
    logic i_sdi_bit = 0, i_rx_valid = 0, i_pready = 0, i_wr = 0, i_rd = 0;
    sdirx_word_s i_rx_word = '0;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    logic o_rx_ready, o_pvalid, o_io_enable, o_sdo_p, o_sdo_n, cab_idle, cab_bit;
    logic [19:0] o_pdata;
    logic [31:0] o_rdata;
    logic [19:0] got[$];
    int n_mismatch = 0;
    int samples_checked = 0;
    int acc_cnt;
    bit a;

    always #50 i_clk = ~i_clk;
    always @(posedge i_clk) if (o_pvalid === 1'b1 && i_pready) got.push_back(o_pdata);

    sdirx_mode_ctrl dut_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_pins(i_pins),
        .i_rate(i_rate), .i_sdi_bit(i_sdi_bit), .i_rx_word(i_rx_word),
        .i_rx_valid(i_rx_valid), .o_rx_ready(o_rx_ready), .o_pdata(o_pdata),
        .o_pvalid(o_pvalid), .i_pready(i_pready), .o_io_enable(o_io_enable),
        .o_sdo_p(o_sdo_p), .o_sdo_n(o_sdo_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata));
    sdirx_cable_model cab_u (.i_sdo_p(o_sdo_p), .i_sdo_n(o_sdo_n), .o_idle(cab_idle),
        .o_bit(cab_bit));

    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task print_verdict;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict

    task wr(input logic [7:0] ad, input logic [31:0] d);
        i_addr <= ad;
        i_wdata <= d;
        i_wr <= 1;
        @(posedge i_clk);
        i_wr <= 0;
        @(posedge i_clk);
    endtask : wr

    task rd_chk(input logic [7:0] ad, input logic [31:0] e);
        i_addr <= ad;
        i_rd <= 1;
        @(posedge i_clk);
        i_rd <= 0;
        @(negedge i_clk);
        check(o_rdata, e);
        @(posedge i_clk);
    endtask : rd_chk

    task pins(input logic [3:0] p);
        i_pins <= p;
        repeat (6) @(posedge i_clk);
    endtask : pins

    task send(input logic [19:0] w, output bit acc);
        i_rx_word <= w;
        i_rx_valid <= 1;
        @(negedge i_clk);
        acc = (o_rx_ready === 1'b1);
        @(posedge i_clk);
    endtask : send

    task push(input logic [19:0] w);
        bit ok;
        ok = 0;
        for (int n = 0; n < 20 && !ok; n++) send(w, ok);
        i_rx_valid <= 0;
        repeat (8) @(posedge i_clk);
    endtask : push

    task loop_chk(input logic en);
        for (int k = 0; k < 4; k++) begin
            i_sdi_bit <= k[0];
            @(posedge i_clk);
            @(negedge i_clk);
            check({o_sdo_p, o_sdo_n}, en ? {k[0], ~k[0]} : 2'b11);
            check({cab_idle, cab_bit}, en ? {1'b0, k[0]} : 2'b10);
            @(posedge i_clk);
        end
    endtask : loop_chk

    initial begin
        #(100 * 5000);
        n_mismatch++;
        print_verdict();
    end

    initial begin
        repeat (12) @(posedge i_clk);
        i_resetn <= 1;
        @(posedge i_clk);
        rd_chk(REG_CTRL, CTRL_RESET);
        rd_chk(REG_STATUS, 32'h0);
        check({o_sdo_p, o_sdo_n, o_pvalid}, 3'b110);
        wr(8'h0c, 32'hffff_ffff);
        wr(REG_STATUS, 32'hffff_ffff);
        rd_chk(8'h0c, 32'h0);
        rd_chk(REG_STATUS, 32'h0);
        check(o_io_enable, 1'b1);
        i_pready <= 1;
        pins(4'b1110);
        rd_chk(REG_STATUS, 32'h7);
        push({10'h3ff, 10'h001});
        check(got.size(), 1);
        check(got.pop_front(), {LEGAL_MAX, LEGAL_MIN});
        wr(REG_CTRL, 32'h0);
        rd_chk(REG_CTRL, 32'h0);
        push({10'h3ff, 10'h001});
        check(got.size(), 1);
        check(got.pop_front(), {10'h3ff, 10'h001});
        pins(4'b1010);
        push({10'h3ff, 10'h001});
        check(got.size(), 1);
        check(got.pop_front(), {10'h3ff, 10'h001});
        pins(4'b0010);
        push({10'h155, 10'h2aa});
        check(got.size(), 2);
        check(got.pop_front(), {10'h000, 10'h155});
        check(got.pop_front(), {10'h000, 10'h2aa});
        pins(4'b1010);
        i_pready <= 0;
        acc_cnt = 0;
        for (int i = 0; i < 24; i++) begin
            send(20'h10000 + i, a);
            if (!a) break;
            acc_cnt++;
        end
        i_rx_valid <= 0;
        @(posedge i_clk);
        check(acc_cnt, FIFO_DEPTH + 1);
        rd_chk(REG_STATUS, 32'h5 | (FIFO_DEPTH << ST_LEVEL_LSB));
        i_pready <= 1;
        repeat (40) @(posedge i_clk);
        check(got.size(), acc_cnt);
        for (int i = 0; i < acc_cnt; i++) check(got.pop_front(), 20'h10000 + i);
        rd_chk(REG_COUNT, 4 + acc_cnt);
        for (int r = 0; r < 8; r++) begin
            i_rate <= r[2:0];
            repeat (2) @(posedge i_clk);
            loop_chk(r < 5);
        end
        i_rate <= 3'h4;
        pins(4'b1000);
        loop_chk(1'b0);
        check(cab_idle, 1'b1);
        pins(4'b1011);
        loop_chk(1'b0);
        check(o_io_enable, 1'b0);
        check(o_rx_ready, 1'b0);
        check(o_pvalid, 1'b0);
        rd_chk(REG_STATUS, 32'h400d);
        print_verdict();
    end
endmodule : sdirx_mode_ctrl_test
